// ### src/hiccup_pkg.sv
/*
  constants, states and timing for the fault and hiccup supervisor.
  assumes a single 25 MHz device clock; analog comparisons arrive as logic levels.
*/
package hiccup_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int ONESHOT_US = 50;
  localparam int BLANK_NS = 100;
  localparam int RESTART_MS = 295;
  localparam int ONESHOT_CYC = (CLK_HZ / 1000000) * ONESHOT_US;
  localparam int BLANK_CYC = (BLANK_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int RESTART_CYC = (CLK_HZ / 1000) * RESTART_MS;
  localparam int CNT_W = 24;
  // ----------------------------------------
  // register bus map
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_RESTARTS = 8'h08;
  localparam int CTRL_HICCUP_EN = 0;
  localparam int CTRL_BLANK_EN = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  // ----------------------------------------
  // states
  // ----------------------------------------
  typedef enum logic [5:0] {
    ST_DISCHARGE = 6'h01,
    ST_SOFTSTART = 6'h02,
    ST_RUN = 6'h04,
    ST_OC_DRAIN = 6'h08,
    ST_SHUTDOWN = 6'h10,
    ST_LOWPOWER = 6'h20
  } sup_state_e;
endpackage

// ### src/blank_timer.sv
/*
  leading-edge blanking counter for the current sense comparisons.
  assumes gate_rise is a one-cycle pulse on the rising drive edge.
*/
`timescale 1ns/1ps
module blank_timer #(
  parameter int CYCLES = hiccup_pkg::BLANK_CYC
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic enable,
  input wire logic gate_rise,
  output logic blanking
);
  typedef struct packed {
    logic [7:0] cnt;
  } blank_s;
  blank_s st_reg;
  blank_s st_next;

  initial
  begin
    if (CYCLES < 1 || CYCLES > 255)
    begin
      $error("blank_timer: CYCLES out of range");
    end
  end

  always_comb
  begin
    st_next = st_reg;
    if (gate_rise && enable)
    begin
      st_next.cnt = 8'(CYCLES); // R15 R16
    end
    else if (st_reg.cnt != 8'h00)
    begin
      st_next.cnt = st_reg.cnt - 8'h01;
    end
    if (!enable)
    begin
      st_next.cnt = 8'h00; // R20
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign blanking = (st_reg.cnt != 8'h00);
endmodule

// ### src/fault_hiccup_supervisor.sv
/*
  fault and overcurrent hiccup supervisor with apb control and status.
  assumes comparator results are synchronous to mclk and the soft-start
  thresholds arrive as comparator levels.
*/
// What this block does
// R1 - any of four monitors raises a fault
// R2 - fault disables drive, fast-discharges soft-start
// R3 - restart needs fault clear, soft-start below reset
// R4 - input-high fault enters low power about 295 ms
// R5 - after delay, restart or repeat shutdown
// R6 - input-low fault shuts down without delay
// R7 - overcurrent shutdown armed after soft-start completes
// R8 - overcurrent swaps charge source for 40 uA discharge
// R9 - retriggerable 50 us one-shot on overcurrent
// R10 - discharge holds while one-shot active
// R11 - below 4.375 V during drain: shut down
// R12 - overcurrent shutdown waits 295 ms, then restarts
// R13 - early overcurrent end restores normal charging
// R14 - threshold above 1.5 V defeats hiccup; code uses ctrl bit CTRL_HICCUP_EN instead
// R15 - ignore current sense first 100 ns
// R16 - blanking starts at drive rising edge
// R17 - blanking masks both current comparisons
// R18 - shutdown discharge continues to 0.27 V reset
// R19 - soft-start completes above error amplifier
// R20 - no blanking while feedback below 2.0 V
// R21 - timers count device clock cycles
`timescale 1ns/1ps
module fault_hiccup_supervisor #(
  parameter int RESTART_CYCLES = hiccup_pkg::RESTART_CYC,
  parameter int ONESHOT_CYCLES = hiccup_pkg::ONESHOT_CYC
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ref_low,
  input wire logic input_high_monitor,
  input wire logic input_low_monitor,
  input wire logic over_temp,
  input wire logic overcurrent,
  input wire logic peak_current_trip,
  input wire logic pwm_gate_request,
  input wire logic feedback_input_low,
  input wire logic ss_below_reset,
  input wire logic ss_below_oc_limit,
  input wire logic ss_above_comp,
  output logic gate_drive,
  output logic ss_charge_on,
  output logic ss_drain_oc,
  output logic ss_drain_fast,
  output logic low_power
);
  // ----------------------------------------
  // parameter checks
  // ----------------------------------------
  initial
  begin
    if (RESTART_CYCLES < 1 || RESTART_CYCLES >= (1 << hiccup_pkg::CNT_W))
    begin
      $error("RESTART_CYCLES out of range");
    end
    if (ONESHOT_CYCLES < 1 || ONESHOT_CYCLES >= (1 << hiccup_pkg::CNT_W))
    begin
      $error("ONESHOT_CYCLES out of range");
    end
  end

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic [1:0] rst_sync_reg;
  logic rst_i_b;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_sync_reg <= 2'h0;
    end
    else
    begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_i_b = rst_sync_reg[1];

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    hiccup_pkg::sup_state_e state;
    logic [hiccup_pkg::CNT_W-1:0] delay_cnt;
    logic [hiccup_pkg::CNT_W-1:0] shot_cnt;
    logic [1:0] ctrl;
    logic high_fault_seen;
    logic oc_shutdown;
    logic gate;
    logic charge;
    logic drain_oc;
    logic drain_fast;
    logic lowp;
    logic [15:0] restarts;
    logic [31:0] rdata;
    logic ready;
  } sup_s;
  sup_s st_reg;
  sup_s st_next;

  logic blanking;
  logic fault;
  logic oc_seen;
  logic pk_seen;
  logic shot_active;
  logic apb_access;

  blank_timer #(
    .CYCLES(hiccup_pkg::BLANK_CYC)
  ) u_blank (
    .mclk(mclk),
    .rst_b(rst_i_b),
    .enable(st_reg.ctrl[hiccup_pkg::CTRL_BLANK_EN] && !feedback_input_low), // R20
    .gate_rise(st_next.gate && !st_reg.gate), // R16
    .blanking(blanking)
  );

  function automatic logic [hiccup_pkg::CNT_W-1:0] cnt_load(input int n);
    cnt_load = (hiccup_pkg::CNT_W)'(n);
  endfunction

  assign fault = ref_low || input_high_monitor || input_low_monitor || over_temp; // R1
  // spikes from the switch edge must not trip either comparison
  assign oc_seen = overcurrent && !blanking; // R17 R15
  assign pk_seen = peak_current_trip && !blanking; // R17
  assign shot_active = (st_reg.shot_cnt != '0);
  assign apb_access = psel && penable && !st_reg.ready;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    st_next = st_reg;
    st_next.ready = 1'b0;
    if (st_reg.delay_cnt != '0)
    begin
      st_next.delay_cnt = st_reg.delay_cnt - cnt_load(1); // R21
    end
    // one-shot reloads while overcurrent persists
    if (oc_seen)
    begin
      st_next.shot_cnt = cnt_load(ONESHOT_CYCLES); // R9 R21
    end
    else if (shot_active)
    begin
      st_next.shot_cnt = st_reg.shot_cnt - cnt_load(1); // R9
    end
    if (input_high_monitor)
    begin
      st_next.high_fault_seen = 1'b1;
    end

    case (st_reg.state)
      hiccup_pkg::ST_DISCHARGE:
      begin
        if (!fault && ss_below_reset)
        begin
          st_next.high_fault_seen = 1'b0;
          if (st_reg.high_fault_seen || st_reg.oc_shutdown)
          begin
            st_next.state = hiccup_pkg::ST_LOWPOWER; // R4 R12
            st_next.delay_cnt = cnt_load(RESTART_CYCLES);
          end
          else
          begin
            st_next.state = hiccup_pkg::ST_SOFTSTART; // R3 R6
          end
          st_next.oc_shutdown = 1'b0;
        end
      end
      hiccup_pkg::ST_SOFTSTART:
      begin
        if (ss_above_comp)
        begin
          st_next.state = hiccup_pkg::ST_RUN; // R19
        end
      end
      hiccup_pkg::ST_RUN:
      begin
        // overcurrent is only acted on here, after soft-start
        if (oc_seen && st_reg.ctrl[hiccup_pkg::CTRL_HICCUP_EN])
        begin
          st_next.state = hiccup_pkg::ST_OC_DRAIN; // R7 R8
        end
      end
      hiccup_pkg::ST_OC_DRAIN:
      begin
        if (ss_below_oc_limit)
        begin
          st_next.state = hiccup_pkg::ST_SHUTDOWN; // R11
          st_next.oc_shutdown = 1'b1;
        end
        else if (!shot_active && !oc_seen)
        begin
          st_next.state = hiccup_pkg::ST_SOFTSTART; // R10 R13
        end
      end
      hiccup_pkg::ST_SHUTDOWN:
      begin
        if (ss_below_reset)
        begin
          st_next.state = hiccup_pkg::ST_LOWPOWER; // R18 R12
          st_next.delay_cnt = cnt_load(RESTART_CYCLES);
          st_next.oc_shutdown = 1'b0;
        end
      end
      hiccup_pkg::ST_LOWPOWER:
      begin
        if (st_reg.delay_cnt == '0)
        begin
          st_next.restarts = st_reg.restarts + 16'h0001;
          if (fault)
          begin
            st_next.state = hiccup_pkg::ST_DISCHARGE; // R5
          end
          else
          begin
            st_next.state = hiccup_pkg::ST_SOFTSTART; // R5 R12
          end
        end
      end
      default:
      begin
        st_next.state = hiccup_pkg::ST_DISCHARGE;
      end
    endcase

    // any fault overrides the sequence, the low-power wait included
    if (fault)
    begin
      st_next.state = hiccup_pkg::ST_DISCHARGE; // R2
    end

    st_next.gate = 1'b0;
    st_next.charge = 1'b0;
    st_next.drain_oc = 1'b0;
    st_next.drain_fast = 1'b0;
    st_next.lowp = 1'b0;
    case (st_next.state)
      hiccup_pkg::ST_SOFTSTART,
      hiccup_pkg::ST_RUN:
      begin
        st_next.charge = 1'b1;
        st_next.gate = pwm_gate_request && !(pk_seen && st_reg.gate);
      end
      hiccup_pkg::ST_OC_DRAIN:
      begin
        st_next.drain_oc = 1'b1; // R8
        st_next.gate = pwm_gate_request && !(pk_seen && st_reg.gate);
      end
      hiccup_pkg::ST_LOWPOWER:
      begin
        st_next.lowp = 1'b1; // R4 R12
      end
      default:
      begin
        st_next.drain_fast = 1'b1; // R2 R18
      end
    endcase

    // ----------------------------------------
    // apb slave, one wait state
    // ----------------------------------------
    st_next.rdata = 32'h0000_0000;
    if (apb_access)
    begin
      st_next.ready = 1'b1;
      if (paddr == hiccup_pkg::ADDR_CTRL)
      begin
        if (pwrite)
        begin
          st_next.ctrl = pwdata[1:0];
        end
        st_next.rdata = {30'h0, st_reg.ctrl};
      end
      else if (paddr == hiccup_pkg::ADDR_STATUS)
      begin
        st_next.rdata = {20'h0, fault, blanking, shot_active, st_reg.lowp,
                         st_reg.gate, st_reg.high_fault_seen, st_reg.state};
      end
      else if (paddr == hiccup_pkg::ADDR_RESTARTS)
      begin
        st_next.rdata = {16'h0, st_reg.restarts};
        if (pwrite)
        begin
          // a restart counted in the same cycle survives the clear
          st_next.restarts = st_next.restarts - st_reg.restarts;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_i_b)
  begin
    if (!rst_i_b)
    begin
      st_reg <= '0;
      st_reg.state <= hiccup_pkg::ST_DISCHARGE;
      st_reg.ctrl <= hiccup_pkg::CTRL_RESET;
      st_reg.drain_fast <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign gate_drive = st_reg.gate;
  assign ss_charge_on = st_reg.charge;
  assign ss_drain_oc = st_reg.drain_oc;
  assign ss_drain_fast = st_reg.drain_fast;
  assign low_power = st_reg.lowp;
  assign prdata = st_reg.rdata;
  assign pready = st_reg.ready;
  assign pslverr = 1'b0;
endmodule

// ### tb/hiccup_chk.sv
/* port assertions for the hiccup supervisor.
   bound to the top module; counts follow its parameters. */
`timescale 1ns/1ps
module hiccup_chk #(
  parameter int RESTART_CYCLES = 50,
  parameter int ONESHOT_CYCLES = 20
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ref_low,
  input wire logic input_high_monitor,
  input wire logic input_low_monitor,
  input wire logic over_temp,
  input wire logic overcurrent,
  input wire logic ss_below_reset,
  input wire logic ss_below_oc_limit,
  input wire logic gate_drive,
  input wire logic ss_charge_on,
  input wire logic ss_drain_oc,
  input wire logic ss_drain_fast,
  input wire logic low_power
);
  logic fault;
  int lp_cnt;
  int quiet_cnt;
  assign fault = ref_low | input_high_monitor | input_low_monitor | over_temp;
  // quiet count saturates so a long run cannot wrap
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lp_cnt <= 0;
      quiet_cnt <= 0;
    end
    else
    begin
      lp_cnt <= low_power ? lp_cnt + 1 : 0;
      quiet_cnt <= overcurrent ? 0 : (quiet_cnt < 9999 ? quiet_cnt + 1 : quiet_cnt);
    end
  end
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  a_fault_gate_off: assert property (fault |=> !gate_drive && ss_drain_fast)
    else $error("drive on in fault");
  a_fast_gate_off: assert property (ss_drain_fast |-> !gate_drive)
    else $error("drive on in discharge");
  a_lp_all_off: assert property (low_power |-> !gate_drive && !ss_charge_on)
    else $error("drive on in low power");
  a_source_swap: assert property (ss_drain_oc |-> !ss_charge_on)
    else $error("charge and drain both on");
  a_drain_cause: assert property ($rose(ss_drain_oc) |-> $past(overcurrent))
    else $error("drain without overcurrent");
  a_restart_clear: assert property ($rose(ss_charge_on) && $past(ss_drain_fast) |->
    $past(ss_below_reset) && !$past(fault))
    else $error("restart too early");
  a_lp_length: assert property ($fell(low_power) |-> lp_cnt == RESTART_CYCLES + 1)
    else $error("low power length");
  a_oneshot_hold: assert property ($fell(ss_drain_oc) && ss_charge_on |->
    quiet_cnt >= ONESHOT_CYCLES - 1)
    else $error("one-shot too short");
  a_drain_trip: assert property (ss_drain_oc && ss_below_oc_limit |=>
    ss_drain_fast && !gate_drive)
    else $error("no shutdown at limit");
  c_lp_end: cover property ($fell(low_power));
  c_recover: cover property ($fell(ss_drain_oc) && ss_charge_on);
  c_trip: cover property (ss_drain_oc && ss_below_oc_limit);
endmodule

// ### tb/power_stage_model.sv
/* soft-start capacitor and its comparators.
   assumes source controls change only at mclk edges. */
`timescale 1ns/1ps
module power_stage_model #(
  parameter int COMP_MV = 3000
) (
  input wire logic mclk,
  input wire logic ss_charge_on,
  input wire logic ss_drain_oc,
  input wire logic ss_drain_fast,
  output logic ss_below_reset,
  output logic ss_below_oc_limit,
  output logic ss_above_comp
);
  // level in mV; slow drain kept gentle so the one-shot can expire first
  int ss_mv = 0;
  always @(posedge mclk)
  begin
    if (ss_drain_fast)
      ss_mv <= ss_mv > 200 ? ss_mv - 200 : 0;
    else if (ss_drain_oc)
      ss_mv <= ss_mv - 2;
    else if (ss_charge_on)
      ss_mv <= ss_mv < 4450 ? ss_mv + 50 : 4500;
  end
  assign ss_below_reset = ss_mv < 270;
  assign ss_below_oc_limit = ss_mv < 4375;
  assign ss_above_comp = ss_mv > COMP_MV;
endmodule

// ### tb/fault_hiccup_supervisor_test.sv
/* self-checking bench for the hiccup supervisor.
   assumes the checker and soft-start model compile first. */
`timescale 1ns/1ps
`define CHK(s, e, a) begin samples_checked++; if ((a) !== (e)) begin fails++; \
  $display("BAD %s exp %0h got %0h", s, e, a); end end
`define WAITF(c, m) n = 0; while ((c) !== 1'b1 && n < m) begin @(posedge mclk); n++; end \
  if ((c) !== 1'b1) fails++;
module fault_hiccup_supervisor_test;
  localparam int RST_N = 50;
  localparam int ONE_N = 20;
  logic mclk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, overcurrent = 0;
  logic pwm_gate_request = 1, feedback_input_low = 0, pready, gate_drive;
  logic peak_current_trip = 0, pslverr;
  logic ss_charge_on, ss_drain_oc, ss_drain_fast, low_power;
  logic ss_below_reset, ss_below_oc_limit, ss_above_comp;
  logic [3:0] flt = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  int fails = 0, samples_checked = 0, seed = 96, n, k, lp_run = 0, lp_last = 0, lp_seen = 0;
  int lp_runs = 0;
  always #20 mclk = ~mclk;
  // reference for the restart delay: length of each low-power run
  always @(posedge mclk)
  begin
    if (low_power === 1'h1)
    begin
      lp_run++;
      lp_seen++;
    end
    else if (lp_run > 0)
    begin
      lp_last = lp_run;
      lp_run = 0;
      lp_runs++;
    end
  end
  fault_hiccup_supervisor #(.RESTART_CYCLES(RST_N), .ONESHOT_CYCLES(ONE_N)) dut (
    .mclk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .ref_low(flt[0]), .input_high_monitor(flt[1]), .input_low_monitor(flt[2]),
    .over_temp(flt[3]), .overcurrent, .peak_current_trip, .pwm_gate_request,
    .feedback_input_low, .ss_below_reset, .ss_below_oc_limit, .ss_above_comp,
    .gate_drive, .ss_charge_on, .ss_drain_oc, .ss_drain_fast, .low_power);
  power_stage_model ps (.mclk, .ss_charge_on, .ss_drain_oc, .ss_drain_fast,
    .ss_below_reset, .ss_below_oc_limit, .ss_above_comp);
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do
    begin
      @(posedge mclk);
      t++;
    end
    while (pready !== 1'h1 && t < 20);
    if (pready !== 1'h1) fails++;
    rd = prdata;
    `CHK("pslverr", 1'h0, pslverr)
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge mclk);
  endtask
  task automatic end_of_test;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge mclk);
    rst_b <= 1'h1;
    repeat (3) @(posedge mclk);
    apb(1'h0, 8'h00, 32'h0);
    `CHK("ctrl", 32'h3, rd)
    apb(1'h1, 8'h0C, $random(seed));
    apb(1'h0, 8'h0C, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    for (int i = 0; i < 4; i++)
    begin
      `WAITF(ss_above_comp, 600)
      lp_seen = 0;
      flt[i] <= 1'h1;
      repeat (4) @(posedge mclk);
      `CHK("gate", 1'h0, gate_drive)
      `CHK("fast", 1'h1, ss_drain_fast)
      flt[i] <= 1'h0;
      `WAITF(ss_below_reset, 100)
      `WAITF(ss_above_comp, 600)
      `CHK("lowpower", i == 1, lp_seen > 0)
    end
    `CHK("lp_len", RST_N + 1, lp_last)
    repeat (40) @(posedge mclk);
    k = 1 + ($random(seed) & 3);
    overcurrent <= 1'h1;
    repeat (k) @(posedge mclk);
    overcurrent <= 1'h0;
    @(posedge mclk);
    `CHK("drain_slow", 1'h1, ss_drain_oc)
    `CHK("charge", 1'h0, ss_charge_on)
    `WAITF(ss_charge_on, 200)
    `CHK("oneshot", 1'h1, n >= ONE_N - 2)
    `CHK("no_trip", 1'h0, ss_drain_fast)
    for (int f = 0; f < 2; f++)
    begin
      repeat (40) @(posedge mclk);
      feedback_input_low <= f[0];
      pwm_gate_request <= 1'h0;
      repeat (2) @(posedge mclk);
      pwm_gate_request <= 1'h1;
      // both comparisons trip in the first sampled cycle of the pulse
      @(posedge mclk);
      overcurrent <= 1'h1;
      peak_current_trip <= 1'h1;
      @(posedge mclk);
      `CHK("gate_on", 1'h1, gate_drive)
      overcurrent <= 1'h0;
      peak_current_trip <= 1'h0;
      @(posedge mclk);
      `CHK("pk_blank", !f[0], gate_drive)
      @(posedge mclk);
      `CHK("blank", f[0], ss_drain_oc)
    end
    `WAITF(ss_charge_on, 200)
    repeat (40) @(posedge mclk);
    apb(1'h1, 8'h00, 32'h2);
    overcurrent <= 1'h1;
    repeat (10) @(posedge mclk);
    overcurrent <= 1'h0;
    `CHK("off", 1'h0, ss_drain_oc)
    apb(1'h1, 8'h00, 32'h3);
    overcurrent <= 1'h1;
    `WAITF(ss_drain_fast, 200)
    `CHK("trip_gate", 1'h0, gate_drive)
    overcurrent <= 1'h0;
    `WAITF(low_power, 100)
    apb(1'h0, 8'h04, 32'h0);
    `CHK("st_lp", 1'h1, rd[8])
    `WAITF(ss_charge_on, 200)
    repeat (10) @(posedge mclk);
    `CHK("hiccup_len", RST_N + 1, lp_last)
    overcurrent <= 1'h1;
    repeat (4) @(posedge mclk);
    overcurrent <= 1'h0;
    `CHK("early", 1'h0, ss_drain_oc)
    apb(1'h0, 8'h08, 32'h0);
    `CHK("restart_cnt", lp_runs, rd)
    apb(1'h1, 8'h08, 32'h1);
    apb(1'h0, 8'h08, 32'h0);
    `CHK("restarts", 32'h0, rd)
    end_of_test();
  end
  initial
  begin
    #(40 * 20000);
    fails++;
    end_of_test();
  end
endmodule
bind fault_hiccup_supervisor hiccup_chk #(.RESTART_CYCLES(RESTART_CYCLES),
  .ONESHOT_CYCLES(ONESHOT_CYCLES)) u_chk (.mclk, .rst_b, .ref_low, .input_high_monitor,
  .input_low_monitor, .over_temp, .overcurrent, .ss_below_reset, .ss_below_oc_limit,
  .gate_drive, .ss_charge_on, .ss_drain_oc, .ss_drain_fast, .low_power);
